// *** clp_buf.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module clp_buf #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
      begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  assign out_data = mem_reg[rd_ptr_reg];
endmodule
`default_nettype wire

// *** clp_far.sv ***
// Far side model: host bus arbiter and external memory port
`timescale 1ns/100ps
`default_nettype none
module clp_far #(
  parameter int DLY = 3
) (
  input wire logic clk,
  input wire logic host_req,
  input wire logic ext_wr,
  output logic host_grant,
  output logic ext_ack
);
  logic [3:0] hcnt_reg;
  logic [3:0] ecnt_reg;
  always_ff @(posedge clk)
  begin
    hcnt_reg <= host_req && !host_grant ? hcnt_reg + 4'h1 : 4'h0;
    host_grant <= host_req && !host_grant && hcnt_reg == 4'(DLY - 1);
  end
  // Own arbitration, blind to the host bus, each word acked DLY cycles after ext_wr rises
  always_ff @(posedge clk)
  begin
    ecnt_reg <= ext_wr && !ext_ack ? ecnt_reg + 4'h1 : 4'h0;
    ext_ack <= ext_wr && !ext_ack && ecnt_reg == 4'(DLY - 1);
  end
endmodule
`default_nettype wire

// *** clp_params.svh ***
// Constants for the channel-list pointer and transfer path block
`ifndef CLP_PARAMS_SVH
`define CLP_PARAMS_SVH
`define CLP_PTR_W 8
`define CLP_WORD_W 16
`define CLP_CSR_W 16
`define CLP_INSTR_LSB 11
`define CLP_INSTR_MSB 13
`define CLP_INSTR_LOAD_START_CUR 3'h1
`define CLP_INSTR_LOAD_FINAL 3'h2
`define CLP_INSTR_INIT 3'h3
`define CLP_MODE_OFF 2'h0
`define CLP_MODE_HOST_A 2'h1
`define CLP_MODE_EXT 2'h2
`define CLP_MODE_HOST_B 2'h3
`define CLP_BUF_DEPTH 2
`endif

// *** clp_pkg.sv ***
// Types for the channel-list pointer and transfer path block
`default_nettype none
package clp_pkg;
  typedef enum logic [1:0] {
    CLP_DST_NONE,
    CLP_DST_HOST,
    CLP_DST_EXT
  } clp_dest_t;
  typedef struct packed {
    logic [15:0] data;
    logic [7:0] addr;
  } clp_sample_t;
  typedef struct packed {
    logic [2:0] instr;
    logic [15:0] wdata;
  } clp_cmd_t;
endpackage
`default_nettype wire

// *** clp_top.sv ***
// Channel-list pointer logic and conversion data path selection
`timescale 1ns/100ps
`default_nettype none
`include "clp_params.svh"
module clp_top
  import clp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire logic [`CLP_CSR_W-1:0] CMD_CSR,
  input wire logic [`CLP_WORD_W-1:0] CMD_WDATA,
  output logic CMD_DONE,
  output logic CMD_REFUSED,
  input wire logic [1:0] MODE_SEL,
  input wire logic EXT_ATTACHED,
  input wire logic SCAN_ACTIVE,
  input wire logic CONV_DONE,
  input wire logic [`CLP_WORD_W-1:0] CONV_DATA,
  output logic CONV_READY,
  output logic [`CLP_PTR_W-1:0] LIST_ADDR,
  output logic SCAN_LAST,
  output logic RANGE_VALID,
  output logic [`CLP_PTR_W-1:0] START_PTR,
  output logic [`CLP_PTR_W-1:0] FINAL_PTR,
  output logic HOST_REQ,
  output logic [`CLP_WORD_W-1:0] HOST_DATA,
  input wire logic HOST_GRANT,
  output logic EXT_WR,
  output logic [`CLP_WORD_W-1:0] EXT_DATA,
  input wire logic EXT_ACK
);
  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic clp_dest_t mode_dest(input logic [1:0] sel, input logic ext_ok);
    clp_dest_t d;
    d = CLP_DST_NONE;
    unique case (sel)
      `CLP_MODE_OFF: d = CLP_DST_NONE;
      `CLP_MODE_HOST_A, `CLP_MODE_HOST_B: d = CLP_DST_HOST;
      `CLP_MODE_EXT: d = ext_ok ? CLP_DST_EXT : CLP_DST_NONE;
    endcase
    return d;
  endfunction

  clp_cmd_t cmd;
  clp_dest_t dest;
  logic active_busy;
  logic [`CLP_PTR_W-1:0] start_reg;
  logic [`CLP_PTR_W-1:0] cur_reg;
  logic [`CLP_PTR_W-1:0] final_reg;
  logic valid_reg;
  logic [`CLP_PTR_W-1:0] cur_next;
  logic [1:0] mode_s1_reg;
  logic [1:0] mode_s2_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;

  assign cmd.instr = CMD_CSR[`CLP_INSTR_MSB:`CLP_INSTR_LSB];
  assign cmd.wdata = CMD_WDATA;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      mode_s1_reg <= 2'h0;
      mode_s2_reg <= 2'h0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end
    else if (CE)
    begin
      mode_s1_reg <= MODE_SEL;
      mode_s2_reg <= mode_s1_reg;
      ext_s1_reg <= EXT_ATTACHED;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  assign dest = mode_dest(mode_s2_reg, ext_s2_reg);
  assign active_busy = SCAN_ACTIVE;

  // ----------------------------------------
  // Pointer logic
  // ----------------------------------------
  always_comb
  begin
    if (cur_reg == final_reg)
    begin
      cur_next = start_reg;
    end
    else
    begin
      cur_next = cur_reg + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      start_reg <= 8'h00;
      cur_reg <= 8'h00;
      final_reg <= 8'h00;
      valid_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (CMD_VALID && !active_busy)
      begin
        unique case (cmd.instr)
          `CLP_INSTR_LOAD_START_CUR:
          begin
            start_reg <= cmd.wdata[15:8];
            cur_reg <= cmd.wdata[7:0];
          end
          `CLP_INSTR_LOAD_FINAL:
          begin
            final_reg <= cmd.wdata[7:0];
            valid_reg <= 1'b1;
          end
          `CLP_INSTR_INIT:
          begin
            start_reg <= 8'h00;
            cur_reg <= 8'h00;
            final_reg <= 8'h00;
            valid_reg <= 1'b0;
          end
          default:
          begin
          end
        endcase
      end
      else if (active_busy && CONV_DONE && CONV_READY && valid_reg)
      begin
        cur_reg <= cur_next;
      end
    end
  end

  // ----------------------------------------
  // Command answer and pointer outputs
  // ----------------------------------------
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      CMD_DONE <= 1'b0;
      CMD_REFUSED <= 1'b0;
      LIST_ADDR <= 8'h00;
      SCAN_LAST <= 1'b0;
      RANGE_VALID <= 1'b0;
      START_PTR <= 8'h00;
      FINAL_PTR <= 8'h00;
    end
    else if (CE)
    begin
      CMD_DONE <= CMD_VALID && !active_busy;
      CMD_REFUSED <= CMD_VALID && active_busy;
      LIST_ADDR <= cur_reg;
      SCAN_LAST <= valid_reg && (cur_reg == final_reg);
      RANGE_VALID <= valid_reg;
      START_PTR <= start_reg;
      FINAL_PTR <= final_reg;
    end
  end

  // ----------------------------------------
  // Data path
  // ----------------------------------------
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  clp_sample_t buf_in;
  clp_sample_t buf_out;
  logic sending_reg;
  clp_dest_t send_dest_reg;

  assign buf_in_valid = CONV_DONE && CONV_READY && (dest != CLP_DST_NONE);
  assign buf_in.data = CONV_DATA;
  assign buf_in.addr = cur_reg;
  assign buf_out_ready = !sending_reg;

  clp_buf #(
    .WIDTH($bits(clp_sample_t))
  ) u_buf (
    .clk(CORE_CLK),
    .rst(SRST),
    .ce(CE),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out)
  );

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      CONV_READY <= 1'b0;
    end
    else if (CE)
    begin
      CONV_READY <= buf_in_ready && !(buf_in_valid && CONV_READY);
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      sending_reg <= 1'b0;
      send_dest_reg <= CLP_DST_NONE;
      HOST_REQ <= 1'b0;
      HOST_DATA <= 16'h0000;
      EXT_WR <= 1'b0;
      EXT_DATA <= 16'h0000;
    end
    else if (CE)
    begin
      if (!sending_reg && buf_out_valid)
      begin
        sending_reg <= 1'b1;
        send_dest_reg <= dest;
        if (dest == CLP_DST_EXT)
        begin
          EXT_WR <= 1'b1;
          EXT_DATA <= buf_out.data;
        end
        else
        begin
          HOST_REQ <= 1'b1;
          HOST_DATA <= buf_out.data;
        end
      end
      else if (sending_reg && send_dest_reg == CLP_DST_EXT && EXT_ACK)
      begin
        EXT_WR <= 1'b0;
        sending_reg <= 1'b0;
      end
      else if (sending_reg && send_dest_reg != CLP_DST_EXT && HOST_GRANT)
      begin
        HOST_REQ <= 1'b0;
        sending_reg <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** clp_top_sva.sv ***
// Concurrent checks on the pointer and transfer path ports
`timescale 1ns/100ps
`default_nettype none
module clp_chk (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire logic [15:0] CMD_CSR,
  input wire logic [15:0] CMD_WDATA,
  input wire logic CMD_DONE,
  input wire logic CMD_REFUSED,
  input wire logic SCAN_ACTIVE,
  input wire logic RANGE_VALID,
  input wire logic [7:0] START_PTR,
  input wire logic [7:0] FINAL_PTR,
  input wire logic HOST_REQ,
  input wire logic [15:0] HOST_DATA,
  input wire logic HOST_GRANT,
  input wire logic EXT_WR,
  input wire logic [15:0] EXT_DATA,
  input wire logic EXT_ACK
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence s_take;
    CE && CMD_VALID && !SCAN_ACTIVE;
  endsequence
  property p_done; s_take |=> CMD_DONE && !CMD_REFUSED; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_ref; CE && CMD_VALID && SCAN_ACTIVE |=> CMD_REFUSED && !CMD_DONE; endproperty
  a_ref: assert property (p_ref) else $error("no refuse");
  property p_load;
    s_take ##0 CMD_CSR[13:11] == 3'h1 |=> ##1 START_PTR == $past(CMD_WDATA[15:8], 2);
  endproperty
  a_load: assert property (p_load) else $error("bad start");
  property p_fin;
    s_take ##0 CMD_CSR[13:11] == 3'h2 |=> ##1 RANGE_VALID && FINAL_PTR == $past(CMD_WDATA[7:0], 2);
  endproperty
  a_fin: assert property (p_fin) else $error("bad final");
  property p_init; s_take ##0 CMD_CSR[13:11] == 3'h3 |=> ##1 !RANGE_VALID; endproperty
  a_init: assert property (p_init) else $error("no clear");
  property p_hold; $past(SCAN_ACTIVE) |-> $stable(START_PTR) && $stable(FINAL_PTR); endproperty
  a_hold: assert property (p_hold) else $error("moved");
  property p_host; HOST_REQ && !HOST_GRANT |=> HOST_REQ && $stable(HOST_DATA); endproperty
  a_host: assert property (p_host) else $error("host drop");
  property p_ext; EXT_WR && !EXT_ACK |=> EXT_WR && $stable(EXT_DATA); endproperty
  a_ext: assert property (p_ext) else $error("ext drop");
endmodule
bind clp_top clp_chk u_chk (
  .CORE_CLK(CORE_CLK),
  .SRST(SRST),
  .CE(CE),
  .CMD_VALID(CMD_VALID),
  .CMD_CSR(CMD_CSR),
  .CMD_WDATA(CMD_WDATA),
  .CMD_DONE(CMD_DONE),
  .CMD_REFUSED(CMD_REFUSED),
  .SCAN_ACTIVE(SCAN_ACTIVE),
  .RANGE_VALID(RANGE_VALID),
  .START_PTR(START_PTR),
  .FINAL_PTR(FINAL_PTR),
  .HOST_REQ(HOST_REQ),
  .HOST_DATA(HOST_DATA),
  .HOST_GRANT(HOST_GRANT),
  .EXT_WR(EXT_WR),
  .EXT_DATA(EXT_DATA),
  .EXT_ACK(EXT_ACK)
);
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the channel-list pointer block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic CORE_CLK = 1'b0, SRST = 1'b1, CE = 1'b1, CMD_VALID = 1'b0, EXT_ATTACHED = 1'b1;
  logic SCAN_ACTIVE = 1'b0, CONV_DONE = 1'b0;
  logic [15:0] CMD_CSR = 16'h0000, CMD_WDATA = 16'h0000, CONV_DATA = 16'h0000;
  logic [1:0] MODE_SEL = 2'h1;
  logic CMD_DONE, CMD_REFUSED, CONV_READY, SCAN_LAST, RANGE_VALID;
  logic HOST_REQ, HOST_GRANT, EXT_WR, EXT_ACK;
  logic [7:0] LIST_ADDR, START_PTR, FINAL_PTR, cur;
  logic [15:0] HOST_DATA, EXT_DATA;
  logic [16:0] seen[$];
  int n_errors = 0, n_tests = 0;
  always #50 CORE_CLK = ~CORE_CLK;
  clp_top uut (
    .CORE_CLK(CORE_CLK),
    .SRST(SRST),
    .CE(CE),
    .CMD_VALID(CMD_VALID),
    .CMD_CSR(CMD_CSR),
    .CMD_WDATA(CMD_WDATA),
    .CMD_DONE(CMD_DONE),
    .CMD_REFUSED(CMD_REFUSED),
    .MODE_SEL(MODE_SEL),
    .EXT_ATTACHED(EXT_ATTACHED),
    .SCAN_ACTIVE(SCAN_ACTIVE),
    .CONV_DONE(CONV_DONE),
    .CONV_DATA(CONV_DATA),
    .CONV_READY(CONV_READY),
    .LIST_ADDR(LIST_ADDR),
    .SCAN_LAST(SCAN_LAST),
    .RANGE_VALID(RANGE_VALID),
    .START_PTR(START_PTR),
    .FINAL_PTR(FINAL_PTR),
    .HOST_REQ(HOST_REQ),
    .HOST_DATA(HOST_DATA),
    .HOST_GRANT(HOST_GRANT),
    .EXT_WR(EXT_WR),
    .EXT_DATA(EXT_DATA),
    .EXT_ACK(EXT_ACK)
  );
  clp_far #(.DLY(3)) far (.clk(CORE_CLK), .host_req(HOST_REQ), .ext_wr(EXT_WR),
    .host_grant(HOST_GRANT), .ext_ack(EXT_ACK));
  always @(posedge CORE_CLK)
  begin
    if (HOST_REQ && HOST_GRANT)
      seen.push_back({1'b0, HOST_DATA});
    if (EXT_WR && EXT_ACK)
      seen.push_back({1'b1, EXT_DATA});
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task tk(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  task bound(input int i);
    if (i >= 40)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task cmd(input logic [2:0] op, input logic [15:0] d, input logic rf);
    CMD_VALID <= 1'b1;
    CMD_CSR <= {2'h0, op, 11'h000};
    CMD_WDATA <= d;
    tk(1);
    CMD_VALID <= 1'b0;
    tk(1);
    chk({CMD_REFUSED, CMD_DONE}, {rf, !rf});
  endtask
  task conv(input logic [15:0] d);
    int i;
  begin
    CONV_DONE <= 1'b1;
    CONV_DATA <= d;
    tk(1);
    for (i = 0; CONV_READY !== 1'b1; i++)
    begin
      tk(1);
      bound(i);
    end
    CONV_DONE <= 1'b0;
    cur = (cur == 8'h04) ? 8'h02 : cur + 8'h01;
    tk(1);
  end
  endtask
  task take(input logic [16:0] e);
    int i;
  begin
    for (i = 0; seen.size() == 0; i++)
    begin
      tk(1);
      bound(i);
    end
    chk(seen.pop_front(), e);
  end
  endtask
  task t_ptr;
    cmd(3'h3, 16'h0000, 1'b0);
    chk(RANGE_VALID, 1'b0);
    cmd(3'h1, 16'h0203, 1'b0);
    cmd(3'h2, 16'h0004, 1'b0);
    tk(1);
    chk({RANGE_VALID, FINAL_PTR, START_PTR, LIST_ADDR}, {1'b1, 8'h04, 8'h02, 8'h03});
    cur = 8'h03;
    SCAN_ACTIVE <= 1'b1;
    tk(1);
    cmd(3'h1, 16'h0909, 1'b1);
    chk(START_PTR, 8'h02);
  endtask
  task t_burst;
    int i;
  begin
    for (i = 0; i < 4; i++)
      conv(16'ha000 + 16'(i));
    for (i = 0; i < 4; i++)
      take({1'b0, 16'ha000 + 16'(i)});
    chk({SCAN_LAST, LIST_ADDR}, {1'b1, cur});
  end
  endtask
  task t_modes;
    int k;
  begin
    for (k = 0; k < 5; k++)
    begin
      MODE_SEL <= (k == 4) ? 2'h2 : 2'(k);
      EXT_ATTACHED <= k < 4;
      tk(4);
      conv(16'hc000 + 16'(k));
      tk(12);
      if (k == 0 || k == 4)
        chk(17'(seen.size()), 17'h0);
      else
        take({k == 2, 16'hc000 + 16'(k)});
      chk({SCAN_LAST, LIST_ADDR}, {cur == 8'h04, cur});
    end
  end
  endtask
  task t_reset;
    SCAN_ACTIVE <= 1'b0;
    SRST <= 1'b1;
    tk(2);
    SRST <= 1'b0;
    tk(2);
    chk({RANGE_VALID, START_PTR, FINAL_PTR, LIST_ADDR}, 32'h0);
    cmd(3'h2, 16'h0007, 1'b0);
    tk(1);
    chk({RANGE_VALID, FINAL_PTR}, {1'b1, 8'h07});
    cmd(3'h3, 16'h0000, 1'b0);
    tk(1);
    chk({RANGE_VALID, FINAL_PTR}, 9'h000);
  endtask
  initial
  begin
    tk(6);
    SRST <= 1'b0;
    tk(3);
    t_ptr();
    t_burst();
    t_modes();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
